/* File: core/pmst_defs.vh */
// Constants for the management serial target
`ifndef PMST_DEFS_VH
`define PMST_DEFS_VH
`define PMST_SOF 2'b01
`define PMST_OP_READ 2'b10
`define PMST_OP_WRITE 2'b01
`define PMST_ADDR_W 5
`define PMST_DATA_W 16
`define PMST_NREGS 32
`define PMST_PAGE_REG 5'h1f
`define PMST_MMD_CTL_REG 5'h0d
`define PMST_MMD_DAT_REG 5'h0e
`define PMST_PAGE_STD 16'h0000
`define PMST_PAGE_W 2
`define PMST_CNT_OP 4'h1
`define PMST_CNT_ADDR 4'h9
`define PMST_CNT_TA 4'h1
`define PMST_CNT_DATA 4'hf
`define PMST_MCLK_MAX_KHZ 12500
`define PMST_CLK_KHZ 100000
`endif

/* File: core/pmst_regmem.v */
// Register storage: paged banks, registered read data
`timescale 1ns/1ps
module pmst_regmem #(
    parameter AW = 7,
    parameter DW = 16
) (
    input wire clk_i,
    input wire we_i,
    input wire [AW-1:0] waddr_i,
    input wire [DW-1:0] wdata_i,
    input wire [AW-1:0] raddr_i,
    output reg [DW-1:0] rdata_o
);
    reg [DW-1:0] mem [0:(1<<AW)-1];
    always @(posedge clk_i) begin
        if (we_i) begin
            mem[waddr_i] <= wdata_i;
        end
        rdata_o <= mem[raddr_i];
    end
endmodule

/* File: core/pmst_top.v */
// Management serial target: frame decoder, open-drain data driver, paged registers
`timescale 1ns/1ps
`include "pmst_defs.vh"
module pmst_top #(
    parameter PW = `PMST_PAGE_W
) (
    input wire clk_i,
    input wire sys_rst_i,
    input wire [4:0] phy_addr_i,
    input wire mdc_i,
    input wire mdio_i,
    output reg mdio_o,
    output reg mdio_oe_o,
    output reg write_strobe_o,
    output reg [4:0] write_reg_o,
    output reg [15:0] write_data_o
);
    localparam ST_IDLE = 3'd0;
    localparam ST_SOF = 3'd1;
    localparam ST_OP = 3'd2;
    localparam ST_ADDR = 3'd3;
    localparam ST_TA = 3'd4;
    localparam ST_DATA = 3'd5;
    localparam ST_HUNT = 3'd6;
    localparam AW = 5 + PW;
    ////////////////////////////////////////////////////////////////////////
    // Synchronisers and edge finding
    reg mdc_s1, mdc_s2, mdc_d;
    reg mdio_s1, mdio_s2;
    wire rise = mdc_s2 & ~mdc_d;
    always @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            mdc_s1 <= 1'b0;
            mdc_s2 <= 1'b0;
            mdc_d <= 1'b0;
            mdio_s1 <= 1'b1;
            mdio_s2 <= 1'b1;
        end else begin
            mdc_s1 <= mdc_i;
            mdc_s2 <= mdc_s1;
            mdc_d <= mdc_s2;
            mdio_s1 <= mdio_i;
            mdio_s2 <= mdio_s1;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // Frame state
    reg [2:0] state;
    reg [3:0] cnt;
    reg first;
    reg is_read;
    reg [14:0] shreg;
    reg match;
    reg [15:0] rd_sh;
    reg [PW-1:0] page;
    reg [15:0] mmd_ctl;
    reg load_rd;
    wire bit_in = mdio_s2;
    wire [14:0] shn = {shreg[13:0], bit_in};
    wire [4:0] reg_sel = shn[4:0];
    wire [4:0] phy_sel = shn[9:5];
    // EEE data window maps to the all-ones bank, which the top page also uses, keyed by the selected index
    function [AW-1:0] map_addr;
        input [PW-1:0] pg;
        input [4:0] ra;
        input [4:0] idx;
        begin
            if (ra == `PMST_MMD_DAT_REG) begin
                map_addr = {{PW{1'b1}}, idx};
            end else if (ra == `PMST_PAGE_REG) begin
                // Page key lives in bank zero, seen from every page
                map_addr = {{PW{1'b0}}, ra};
            end else begin
                map_addr = {pg, ra};
            end
        end
    endfunction
    wire [AW-1:0] rd_addr = map_addr(page, reg_sel, mmd_ctl[4:0]);
    wire [15:0] rd_word;
    reg we;
    reg [AW-1:0] waddr;
    reg [15:0] wdata;
    pmst_regmem #(.AW(AW), .DW(16)) u_mem (
        .clk_i(clk_i),
        .we_i(we),
        .waddr_i(waddr),
        .wdata_i(wdata),
        .raddr_i(rd_addr),
        .rdata_o(rd_word)
    );
    reg [4:0] reg_q;
    always @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state <= ST_HUNT;
            cnt <= 4'h0;
            first <= 1'b1;
            is_read <= 1'b0;
            shreg <= 15'h0000;
            match <= 1'b0;
            rd_sh <= 16'h0000;
            page <= {PW{1'b0}};
            mmd_ctl <= 16'h0000;
            load_rd <= 1'b0;
            we <= 1'b0;
            waddr <= {AW{1'b0}};
            wdata <= 16'h0000;
            reg_q <= 5'h00;
            mdio_o <= 1'b0;
            mdio_oe_o <= 1'b0;
            write_strobe_o <= 1'b0;
            write_reg_o <= 5'h00;
            write_data_o <= 16'h0000;
        end else begin
            we <= 1'b0;
            write_strobe_o <= 1'b0;
            load_rd <= 1'b0;
            if (load_rd) begin
                rd_sh <= rd_word;
            end
            if (rise) begin
                shreg <= shn;
                cnt <= cnt - 4'h1;
                case (state)
                    ST_HUNT: begin
                        // Need two ones before the first frame, one after
                        if (bit_in) begin
                            first <= 1'b0;
                            if (!first) begin
                                state <= ST_IDLE;
                            end
                        end
                    end
                    ST_IDLE: begin
                        mdio_oe_o <= 1'b0;
                        if (!bit_in) begin
                            state <= ST_SOF;
                        end
                    end
                    ST_SOF: begin
                        if (bit_in) begin
                            state <= ST_OP;
                            cnt <= `PMST_CNT_OP;
                        end else begin
                            state <= ST_HUNT;
                        end
                    end
                    ST_OP: begin
                        if (cnt == 4'h0) begin
                            if (shn[1:0] == `PMST_OP_READ || shn[1:0] == `PMST_OP_WRITE) begin
                                is_read <= (shn[1:0] == `PMST_OP_READ);
                                state <= ST_ADDR;
                                cnt <= `PMST_CNT_ADDR;
                            end else begin
                                state <= ST_HUNT;
                            end
                        end
                    end
                    ST_ADDR: begin
                        if (cnt == 4'h0) begin
                            match <= (phy_sel == phy_addr_i);
                            reg_q <= reg_sel;
                            load_rd <= is_read;
                            state <= ST_TA;
                            cnt <= `PMST_CNT_TA;
                        end
                    end
                    ST_TA: begin
                        if (is_read && match) begin
                            if (cnt != 4'h0) begin
                                // First turnaround bit was left released; launch the zero
                                mdio_oe_o <= 1'b1;
                                mdio_o <= 1'b0;
                            end else begin
                                // Most significant data bit launched on second turnaround rise
                                mdio_oe_o <= ~rd_sh[15];
                                rd_sh <= {rd_sh[14:0], 1'b0};
                            end
                        end
                        if (cnt == 4'h0) begin
                            state <= ST_DATA;
                            cnt <= `PMST_CNT_DATA;
                        end
                    end
                    ST_DATA: begin
                        if (is_read && match && cnt != 4'h0) begin
                            // Open drain: pull low only for a zero bit
                            mdio_oe_o <= ~rd_sh[15];
                            rd_sh <= {rd_sh[14:0], 1'b0};
                        end
                        if (cnt == 4'h0) begin
                            state <= ST_IDLE;
                            if (!is_read && match) begin
                                we <= 1'b1;
                                waddr <= map_addr(page, reg_q, mmd_ctl[4:0]);
                                wdata <= {shreg[14:0], bit_in};
                                write_strobe_o <= 1'b1;
                                write_reg_o <= reg_q;
                                write_data_o <= {shreg[14:0], bit_in};
                                if (reg_q == `PMST_PAGE_REG) begin
                                    page <= {shreg[PW-2:0], bit_in};
                                end
                                if (reg_q == `PMST_MMD_CTL_REG) begin
                                    mmd_ctl <= {shreg[14:0], bit_in};
                                end
                            end
                        end
                    end
                    default: state <= ST_HUNT;
                endcase
            end
            if (state == ST_DATA && rise && cnt == 4'h0) begin
                mdio_oe_o <= 1'b0;
            end
        end
    end
endmodule

/* File: verif/pmst_top_assertions.sv */
// Concurrent checks on the management serial target ports
`timescale 1ns/1ps
module pmst_top_assertions #(parameter PW = 2) (
    input wire clk_i,
    input wire sys_rst_i,
    input wire [4:0] phy_addr_i,
    input wire mdc_i,
    input wire mdio_i,
    input wire mdio_o,
    input wire mdio_oe_o,
    input wire write_strobe_o,
    input wire [4:0] write_reg_o,
    input wire [15:0] write_data_o
);
    reg mdc_q;
    reg [7:0] gap;
    // Cycles since the last link clock rise, saturating
    always @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            mdc_q <= 1'b0;
            gap <= 8'hff;
        end else begin
            mdc_q <= mdc_i;
            gap <= (mdc_i && !mdc_q) ? 8'h00 : gap + {7'h00, gap != 8'hff};
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    AST_OD: assert property (mdio_oe_o |-> !mdio_o) else $error("drive not low");
    AST_LAUNCH: assert property ($changed(mdio_oe_o) |-> gap inside {[1:7]}) else $error("drive off rise");
    AST_HOLD: assert property (gap > 8'h08 && gap != 8'hff |-> $stable(mdio_oe_o)) else $error("bit moved");
    AST_IDLE: assert property (gap == 8'hff |-> !mdio_oe_o) else $error("driven while idle");
    AST_PULSE: assert property (write_strobe_o |=> !write_strobe_o) else $error("strobe too long");
    AST_SAMPLE: assert property (write_strobe_o |-> gap inside {[1:7]}) else $error("strobe off rise");
    AST_WR_QUIET: assert property (write_strobe_o |-> !mdio_oe_o && !$past(mdio_oe_o))
        else $error("drive in write");
    AST_WR_HOLD: assert property (!write_strobe_o |-> $stable(write_reg_o) && $stable(write_data_o))
        else $error("write outputs moved");
    cover property (write_strobe_o);
    cover property ($rose(mdio_oe_o));
    cover property (mdio_oe_o ##[1:300] gap == 8'hff);
endmodule

bind pmst_top pmst_top_assertions #(.PW(PW)) chk (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .phy_addr_i(phy_addr_i),
    .mdc_i(mdc_i), .mdio_i(mdio_i), .mdio_o(mdio_o), .mdio_oe_o(mdio_oe_o), .write_strobe_o(write_strobe_o),
    .write_reg_o(write_reg_o), .write_data_o(write_data_o));

/* File: verif/pmst_mgr.sv */
// Station manager model: link clock and frames on the shared line
`timescale 1ns/1ps
module pmst_mgr (
    output logic mdc_o,
    output logic pull_o,
    input wire logic line_i
);
    initial begin
        mdc_o = 1'b0;
        pull_o = 1'b0;
    end
    // One bit period; only pulls low or releases
    task bit_out(input logic b, input logic drv, input realtime half, output logic s);
        pull_o = drv && !b;
        #half;
        s = line_i;
        mdc_o = 1'b1;
        #half;
        mdc_o = 1'b0;
    endtask
    // Ones, then 32 bits; keeps the last 18 line samples
    task frame(input [3:0] hdr, input [9:0] adr, input [15:0] d, input int pre, input realtime half,
        output logic [17:0] rd);
        logic [31:0] w;
        logic s;
        w = {hdr, adr, 2'b10, d};
        rd = '0;
        repeat (pre) bit_out(1'b1, 1'b0, half, s);
        for (int i = 31; i >= 0; i--) begin
            bit_out(w[i], i > 17 || hdr[1:0] != 2'b10, half, s);
            if (i < 18) rd = {rd[16:0], s};
        end
        pull_o = 1'b0;
    endtask
endmodule

/* File: verif/test_pmst_top.sv */
// Testbench for the management serial target
`timescale 1ns/1ps
module test_pmst_top;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [4:0] phy_addr_i = 5'h0a;
    wire mdc, pull, line, mdio_o, mdio_oe_o, write_strobe_o;
    wire [4:0] write_reg_o;
    wire [15:0] write_data_o;
    logic [22:0] q[$];
    logic [17:0] rd;
    logic [15:0] x = 16'ha2e6;
    int err_total = 0, compares = 0, cyc = 0;
    assign line = !(mdio_oe_o || pull);
    pmst_top dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .phy_addr_i(phy_addr_i), .mdc_i(mdc), .mdio_i(line),
        .mdio_o(mdio_o), .mdio_oe_o(mdio_oe_o), .write_strobe_o(write_strobe_o), .write_reg_o(write_reg_o),
        .write_data_o(write_data_o));
    pmst_mgr mgr (.mdc_o(mdc), .pull_o(pull), .line_i(line));
    initial forever #5 clk_i = ~clk_i;
    function logic [15:0] rnd();
        x = x ^ (x << 7);
        x = x ^ (x >> 9);
        x = x ^ (x << 8);
        return x;
    endfunction
    function logic [22:0] take();
        return q.size() ? q.pop_front() : 'x;
    endfunction
    task check(input logic [22:0] seen, input logic [22:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task complete_run();
        $display("errors %0d compares %0d", err_total, compares);
        if (err_total == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task fr(input [3:0] h, input [9:0] a, input [15:0] d, input int pre, input realtime hf);
        @(posedge clk_i) #1;
        mgr.frame(h, a, d, pre, hf, rd);
    endtask
    task wr(input [4:0] pa, input [4:0] ra, input [15:0] d, input int pre);
        if (pa == phy_addr_i) q.push_back({2'b00, ra, d});
        fr(4'b0101, {pa, ra}, d, pre, 62.5);
    endtask
    task rdc(input [4:0] pa, input [4:0] ra, input [15:0] d, input int pre, input realtime hf);
        q.push_back(pa == phy_addr_i ? {5'h1f, 2'b10, d} : {5'h1f, 18'h3_ffff});
        fr(4'b0110, {pa, ra}, 16'hffff, pre, hf);
        check({5'h1f, rd}, take());
    endtask
    // Write notes are taken off the queue when the strobe shows
    always @(negedge clk_i) begin
        cyc++;
        if (write_strobe_o === 1'b1) check({2'b00, write_reg_o, write_data_o}, take());
        if (cyc == 20000) begin
            err_total++;
            complete_run();
        end
    end
    initial begin
        logic [15:0] d;
        logic [4:0] ra;
        repeat (6) @(posedge clk_i);
        #1 sys_rst_i = 1'b0;
        for (int i = 0; i < 4; i++) begin
            ra = 5'(rnd() % 12 + 1);
            d = rnd();
            wr(phy_addr_i, ra, d, i == 0 ? 2 : i - 1);
            rdc(phy_addr_i, ra, d, 0, 62.5);
        end
        wr(phy_addr_i ^ 5'h01, ra, ~d, 1);
        rdc(phy_addr_i ^ 5'h01, ra, d, 1, 62.5);
        fr(4'b0111, 10'h3ff, 16'hffff, 1, 62.5);
        fr(4'b0011, 10'h3ff, 16'hffff, 1, 62.5);
        rdc(phy_addr_i, ra, d, 1, 200.0);
        wr(phy_addr_i, 5'h1f, 16'h0001, 0);
        wr(phy_addr_i, ra, ~d, 0);
        wr(phy_addr_i, 5'h1f, 16'h0000, 0);
        rdc(phy_addr_i, ra, d, 0, 62.5);
        wr(phy_addr_i, 5'h0d, 16'h0003, 0);
        wr(phy_addr_i, 5'h0e, d ^ 16'h5a5a, 0);
        rdc(phy_addr_i, 5'h0e, d ^ 16'h5a5a, 0, 62.5);
        repeat (20) @(posedge clk_i);
        complete_run();
    end
endmodule
